// [rtl/multichannel_scan_grader.sv]
// Multichannel scan grader: APB registers, scan sequencer, limit grading and
// the scan port (judgment group, clock pulse, completion strobe).
// Assumes trigger and measurement inputs are synchronous to pclk and that the
// external measurement front end answers every meas_start with one meas_valid.
//
// Behaviour
// - Scan channels in turn, up to 100, grading each result against the limits.
// - Channel count is programmable from 1 to 100.
// - Pause of 400 to 30000 ms before every channel measurement.
// - Scan starts on handler trigger pulse or local trigger key.
// - External trigger active edge is rising or falling by setting.
// - A trigger starts a whole scan, never a single measurement.
// - Between limits is in, below lower is below, above upper is above.
// - Absolute mode compares the measurement directly with absolute limits.
// - Percent mode compares (measured minus reference)/reference in percent.
// - Above-limit output is driven for an above grade.
// - Below-limit output is driven for a below grade.
// - Pass output is driven for an in-limit grade.
// - A relay line is part of every per-channel output group.
// - One clock pulse per output group, rising on the same edge as that group's lines.
// - One completion strobe pulse after the last group.
// - Results are presented per channel and stop when the scan ends.
`timescale 1ns/1ps
module multichannel_scan_grader #(
    parameter int MS_CYCLES = scan_grader_pkg::CYCLES_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [scan_grader_pkg::DATA_W-1:0] pwdata,
    output logic [scan_grader_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_in,
    output logic meas_start,
    output logic [scan_grader_pkg::CH_W-1:0] meas_channel,
    input wire logic meas_valid,
    input wire logic [scan_grader_pkg::RES_W-1:0] meas_value,
    output scan_grader_pkg::grade_group_t scan_group,
    output logic scan_clock,
    output logic scan_complete_pulse
);
    import scan_grader_pkg::*;

    // Register state
    logic absolute_limit_mode_reg, absolute_limit_mode_next;
    logic rising_edge_sel_reg, rising_edge_sel_next;
    logic soft_start_reg, soft_start_next;
    logic [CH_W-1:0] ch_count_reg, ch_count_next;
    logic [MS_W-1:0] delay_ms_reg, delay_ms_next;
    logic [RES_W-1:0] ref_reg, ref_next;
    logic [RES_W-1:0] upper_reg, upper_next;
    logic [RES_W-1:0] lower_reg, lower_next;
    logic [DATA_W-1:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic mapped;
    logic wr_en;

    // Sequencer state
    scan_state_t state_reg, state_next;
    logic [CH_W-1:0] chan_reg, chan_next;
    logic [MS_W-1:0] ms_left_reg, ms_left_next;
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic [3:0] pulse_cnt_reg, pulse_cnt_next;
    logic trig_prev_reg;
    grade_t grade_reg, grade_next;
    logic [RES_W-1:0] result_reg, result_next;
    grade_group_t group_reg, group_next;
    logic clock_reg, clock_next;
    logic strobe_reg, strobe_next;
    logic meas_start_reg, meas_start_next;
    logic busy;
    logic ext_edge;
    grade_t grade_now;

    // Grading arithmetic
    logic signed [47:0] dev_scaled;
    logic signed [47:0] upper_scaled;
    logic signed [47:0] lower_scaled;

    assign busy = (state_reg != ST_IDLE);
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= RESULT_OFS);
    assign wr_en = psel && penable && pready_reg && pwrite && mapped;
    // Edge chosen by setting; a held level never restarts a scan
    assign ext_edge = rising_edge_sel_reg ? (trigger_in && !trig_prev_reg)
                                          : (!trigger_in && trig_prev_reg);

    // Percent mode avoids a divider: dev*100 against limit*ref, all signed
    always_comb begin
        dev_scaled = ($signed(48'(meas_value)) - $signed(48'(ref_reg))) * $signed(48'(PCT_SCALE));
        upper_scaled = 48'($signed(upper_reg)) * $signed(48'(ref_reg));
        lower_scaled = 48'($signed(lower_reg)) * $signed(48'(ref_reg));
        grade_now = GRADE_IN;
        if (absolute_limit_mode_reg) begin
            if (meas_value > upper_reg) begin
                grade_now = GRADE_ABOVE;
            end else if (meas_value < lower_reg) begin
                grade_now = GRADE_BELOW;
            end
        end else begin
            if (dev_scaled > upper_scaled) begin
                grade_now = GRADE_ABOVE;
            end else if (dev_scaled < lower_scaled) begin
                grade_now = GRADE_BELOW;
            end
        end
    end

    // APB slave: zero wait states, answer registered in the setup cycle
    always_comb begin
        absolute_limit_mode_next = absolute_limit_mode_reg;
        rising_edge_sel_next = rising_edge_sel_reg;
        soft_start_next = 1'b0;
        ch_count_next = ch_count_reg;
        delay_ms_next = delay_ms_reg;
        ref_next = ref_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        prdata_next = prdata_reg;
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !mapped;
        if (psel && !penable) begin
            prdata_next = '0;
            if (!pwrite) begin
                case (paddr)
                    CTRL_OFS: begin
                        prdata_next[CTRL_MODE_BIT] = absolute_limit_mode_reg;
                        prdata_next[CTRL_EDGE_BIT] = rising_edge_sel_reg;
                        prdata_next[CTRL_CH_LSB +: CH_W] = ch_count_reg;
                    end
                    DELAY_OFS: prdata_next[MS_W-1:0] = delay_ms_reg;
                    REF_OFS: prdata_next[RES_W-1:0] = ref_reg;
                    UPPER_OFS: prdata_next[RES_W-1:0] = upper_reg;
                    LOWER_OFS: prdata_next[RES_W-1:0] = lower_reg;
                    STATUS_OFS: begin
                        prdata_next[0] = busy;
                        prdata_next[STAT_CH_LSB +: CH_W] = chan_reg;
                        prdata_next[STAT_GRADE_LSB +: 2] = grade_reg;
                    end
                    RESULT_OFS: prdata_next[RES_W-1:0] = result_reg;
                    default: prdata_next = '0;
                endcase
            end
        end
        // Settings change only between scans so a running scan stays coherent
        if (wr_en) begin
            case (paddr)
                CTRL_OFS: begin
                    soft_start_next = pwdata[CTRL_START_BIT];
                    if (!busy) begin
                        absolute_limit_mode_next = pwdata[CTRL_MODE_BIT];
                        rising_edge_sel_next = pwdata[CTRL_EDGE_BIT];
                        ch_count_next = pwdata[CTRL_CH_LSB +: CH_W];
                        if (pwdata[CTRL_CH_LSB +: CH_W] < CH_MIN) begin
                            ch_count_next = CH_MIN;
                        end else if (pwdata[CTRL_CH_LSB +: CH_W] > CH_MAX) begin
                            ch_count_next = CH_MAX;
                        end
                    end
                end
                DELAY_OFS: begin
                    if (!busy) begin
                        delay_ms_next = pwdata[MS_W-1:0];
                        if (pwdata[MS_W-1:0] < DELAY_MIN_MS) begin
                            delay_ms_next = DELAY_MIN_MS;
                        end else if (pwdata[MS_W-1:0] > DELAY_MAX_MS) begin
                            delay_ms_next = DELAY_MAX_MS;
                        end
                    end
                end
                REF_OFS: if (!busy) ref_next = pwdata[RES_W-1:0];
                UPPER_OFS: if (!busy) upper_next = pwdata[RES_W-1:0];
                LOWER_OFS: if (!busy) lower_next = pwdata[RES_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            absolute_limit_mode_reg <= 1'b1;
            rising_edge_sel_reg <= 1'b1;
            soft_start_reg <= 1'b0;
            ch_count_reg <= CH_RESET;
            delay_ms_reg <= DELAY_RESET;
            ref_reg <= '0;
            upper_reg <= '0;
            lower_reg <= '0;
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            absolute_limit_mode_reg <= absolute_limit_mode_next;
            rising_edge_sel_reg <= rising_edge_sel_next;
            soft_start_reg <= soft_start_next;
            ch_count_reg <= ch_count_next;
            delay_ms_reg <= delay_ms_next;
            ref_reg <= ref_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Scan sequencer
    always_comb begin
        state_next = state_reg;
        chan_next = chan_reg;
        ms_left_next = ms_left_reg;
        tick_cnt_next = tick_cnt_reg;
        pulse_cnt_next = pulse_cnt_reg;
        grade_next = grade_reg;
        result_next = result_reg;
        group_next = group_reg;
        clock_next = 1'b0;
        strobe_next = 1'b0;
        meas_start_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // Trigger opens a whole scan; busy states never look at it
                if (ext_edge || soft_start_reg) begin
                    state_next = ST_DELAY;
                    chan_next = CH_MIN;
                    ms_left_next = delay_ms_reg;
                    tick_cnt_next = '0;
                end
            end
            ST_DELAY: begin
                // Millisecond tick from a divider, then countdown of the pause
                if (tick_cnt_reg == 32'(MS_CYCLES - 1)) begin
                    tick_cnt_next = '0;
                    if (ms_left_reg == 15'h0001) begin
                        state_next = ST_MEASURE;
                        meas_start_next = 1'b1;
                    end else begin
                        ms_left_next = ms_left_reg - 15'h0001;
                    end
                end else begin
                    tick_cnt_next = tick_cnt_reg + 32'h00000001;
                end
            end
            ST_MEASURE: begin
                if (meas_valid) begin
                    grade_next = grade_now;
                    result_next = meas_value;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Group lines change here, on the same edge as the clock rises
                group_next.relay = 1'b1;
                group_next.pass = (grade_reg == GRADE_IN);
                group_next.below_limit_grade = (grade_reg == GRADE_BELOW);
                group_next.above_limit_grade = (grade_reg == GRADE_ABOVE);
                state_next = ST_CLOCK;
                pulse_cnt_next = '0;
                clock_next = 1'b1;
            end
            ST_CLOCK: begin
                clock_next = 1'b1;
                if (pulse_cnt_reg == PULSE_LAST) begin
                    clock_next = 1'b0;
                    state_next = ST_HOLD;
                end else begin
                    pulse_cnt_next = pulse_cnt_reg + 4'h1;
                end
            end
            ST_HOLD: begin
                // Group holds past the falling clock edge until the next channel's setup or the end of the strobe
                if (chan_reg >= ch_count_reg) begin
                    state_next = ST_STROBE;
                    pulse_cnt_next = '0;
                    strobe_next = 1'b1;
                end else begin
                    chan_next = chan_reg + 7'h01;
                    ms_left_next = delay_ms_reg;
                    tick_cnt_next = '0;
                    state_next = ST_DELAY;
                end
            end
            ST_STROBE: begin
                strobe_next = 1'b1;
                if (pulse_cnt_reg == PULSE_LAST) begin
                    strobe_next = 1'b0;
                    group_next = '0;
                    state_next = ST_IDLE;
                end else begin
                    pulse_cnt_next = pulse_cnt_reg + 4'h1;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            chan_reg <= '0;
            ms_left_reg <= '0;
            tick_cnt_reg <= '0;
            pulse_cnt_reg <= '0;
            trig_prev_reg <= 1'b0;
            grade_reg <= GRADE_NONE;
            result_reg <= '0;
            group_reg <= '0;
            clock_reg <= 1'b0;
            strobe_reg <= 1'b0;
            meas_start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            ms_left_reg <= ms_left_next;
            tick_cnt_reg <= tick_cnt_next;
            pulse_cnt_reg <= pulse_cnt_next;
            trig_prev_reg <= trigger_in;
            grade_reg <= grade_next;
            result_reg <= result_next;
            group_reg <= group_next;
            clock_reg <= clock_next;
            strobe_reg <= strobe_next;
            meas_start_reg <= meas_start_next;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign meas_start = meas_start_reg;
    assign meas_channel = chan_reg;
    assign scan_group = group_reg;
    assign scan_clock = clock_reg;
    assign scan_complete_pulse = strobe_reg;
endmodule

// [rtl/scan_grader_pkg.sv]
// Package for the multichannel scan grader: register map, field positions,
// reset values, timing counts and shared types.
// Assumes a 10 MHz APB clock; the long millisecond divider is a top parameter.
package scan_grader_pkg;
    localparam int DATA_W = 32;
    localparam int RES_W = 24;
    localparam int CH_W = 7;
    localparam int MS_W = 15;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DELAY_OFS = 8'h04;
    localparam logic [7:0] REF_OFS = 8'h08;
    localparam logic [7:0] UPPER_OFS = 8'h0C;
    localparam logic [7:0] LOWER_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] RESULT_OFS = 8'h18;
    // Control and status fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_CH_LSB = 8;
    localparam int STAT_CH_LSB = 8;
    localparam int STAT_GRADE_LSB = 16;
    // Reset values and legal ranges
    localparam logic [CH_W-1:0] CH_MIN = 7'h01;
    localparam logic [CH_W-1:0] CH_MAX = 7'h64;
    localparam logic [MS_W-1:0] DELAY_MIN_MS = 15'h0190;
    localparam logic [MS_W-1:0] DELAY_MAX_MS = 15'h7530;
    localparam logic [CH_W-1:0] CH_RESET = CH_MAX;
    localparam logic [MS_W-1:0] DELAY_RESET = DELAY_MIN_MS;
    // Timing and percent scale
    localparam int CLK_HZ = 10000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam int PULSE_NS = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYCLES - 1);
    localparam logic [6:0] PCT_SCALE = 7'h64;

    typedef enum logic [1:0] {
        GRADE_NONE = 2'b00,
        GRADE_IN = 2'b01,
        GRADE_BELOW = 2'b10,
        GRADE_ABOVE = 2'b11
    } grade_t;

    // One per-channel output group as driven on the scan port
    typedef struct packed {
        logic relay;
        logic pass;
        logic below_limit_grade;
        logic above_limit_grade;
    } grade_group_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_MEASURE = 3'b010,
        ST_SETUP = 3'b011,
        ST_CLOCK = 3'b100,
        ST_HOLD = 3'b101,
        ST_STROBE = 3'b110
    } scan_state_t;
endpackage

// [sim/scan_grader_sva.sv]
// Checker for the scan grader: APB answer and scan port timing.
// Sees only the top module's ports; bound from the testbench top file.
`timescale 1ns/1ps
module scan_grader_sva
    import scan_grader_pkg::*;
#(
    parameter int MS_CYCLES = 4
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [DATA_W-1:0] pwdata,
    input logic [DATA_W-1:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic trigger_in,
    input logic meas_start,
    input logic [CH_W-1:0] meas_channel,
    input logic meas_valid,
    input logic [RES_W-1:0] meas_value,
    input grade_group_t scan_group,
    input logic scan_clock,
    input logic scan_complete_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Zero wait states, and an answer only inside an access cycle
    apb_zero_wait_a: assert property ($rose(penable) && psel |-> pready) else $error("pready late");
    apb_answer_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    apb_slverr_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h18))
        else $error("pslverr wrong");
    clock_width_a: assert property ($rose(scan_clock) |-> scan_clock [*8] ##1 scan_clock [*2] ##1 !scan_clock)
        else $error("clock pulse width");
    // Group must not move after the clock's first high cycle nor in the hold cycle
    group_stable_a: assert property ((scan_clock && $past(scan_clock)) || $fell(scan_clock) |-> $stable(scan_group))
        else $error("group moved under clock");
    group_onehot_a: assert property (scan_clock |-> scan_group.relay && $onehot({scan_group.pass,
        scan_group.below_limit_grade, scan_group.above_limit_grade}))
        else $error("group not one grade");
    strobe_width_a: assert property ($rose(scan_complete_pulse) |->
        scan_complete_pulse [*8] ##1 scan_complete_pulse [*2] ##1 !scan_complete_pulse)
        else $error("strobe width");
    strobe_alone_a: assert property (scan_complete_pulse |-> !scan_clock && !meas_start) else $error("strobe overlap");
    group_clear_a: assert property ($fell(scan_complete_pulse) |-> ##[0:1] scan_group == 4'h0)
        else $error("group not cleared");
    meas_pulse_a: assert property (meas_start |=> !meas_start) else $error("meas_start too long");
    meas_chan_a: assert property (meas_start |-> meas_channel >= 7'h01 && meas_channel <= 7'h64)
        else $error("channel out of range");
    clock_cov: cover property ($rose(scan_clock));
    strobe_cov: cover property ($rose(scan_complete_pulse));
    err_cov: cover property (pready && pslverr);
endmodule

// [sim/fixture_model.sv]
// Measurement fixture on the far side: answers each meas_start with one
// meas_valid, value step*channel, promptly or after eight cycles.
// Assumes meas_start is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ps
module fixture_model
    import scan_grader_pkg::*;
(
    input logic pclk,
    input logic presetn,
    input logic meas_start,
    input logic [scan_grader_pkg::CH_W-1:0] meas_channel,
    input logic [scan_grader_pkg::RES_W-1:0] step,
    input logic slow,
    output logic meas_valid,
    output logic [scan_grader_pkg::RES_W-1:0] meas_value
);
    logic busy;
    logic [3:0] wait_cnt;
    logic [RES_W-1:0] held;
    // Outside the valid cycle the value is inverted so a stale sample shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            meas_valid <= 1'b0;
            meas_value <= '0;
            held <= '0;
        end else begin
            meas_valid <= 1'b0;
            meas_value <= ~held;
            if (meas_start) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 4'h7 : 4'h0;
                held <= RES_W'(step * meas_channel);
            end else if (busy) begin
                if (wait_cnt == 4'h0) begin
                    busy <= 1'b0;
                    meas_valid <= 1'b1;
                    meas_value <= held;
                end else begin
                    wait_cnt <= wait_cnt - 4'h1;
                end
            end
        end
    end
endmodule

// [sim/multichannel_scan_grader_test.sv]
// Testbench: APB register checks and three short scans graded by the fixture.
// Assumes MS_CYCLES is shrunk to 4 so a 400 ms pause is 1600 cycles.
`timescale 1ns/1ps
module multichannel_scan_grader_test;
    import scan_grader_pkg::*;
    localparam int MS_CYCLES = 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trigger_in = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, ev, meas_start, meas_valid, scan_clock, scan_complete_pulse, clk_d = 1'b0, scan_complete_pulse_d = 1'b0;
    logic [CH_W-1:0] meas_channel;
    logic [RES_W-1:0] meas_value;
    grade_group_t scan_group;
    logic [3:0] grp_q [$];
    int failures = 0, cmp_count = 0, strobes = 0;
    always #50 pclk = ~pclk;
    multichannel_scan_grader #(.MS_CYCLES(MS_CYCLES)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_in(trigger_in), .meas_start(meas_start), .meas_channel(meas_channel),
        .meas_valid(meas_valid), .meas_value(meas_value), .scan_group(scan_group), .scan_clock(scan_clock),
        .scan_complete_pulse(scan_complete_pulse));
    fixture_model u_fix (.pclk(pclk), .presetn(presetn), .meas_start(meas_start), .meas_channel(meas_channel),
        .step(24'h000190), .slow(slow), .meas_valid(meas_valid), .meas_value(meas_value));
    // Record each group in its hold cycle, after the clock has fallen
    always @(posedge pclk) begin
        clk_d <= scan_clock;
        scan_complete_pulse_d <= scan_complete_pulse;
        if (clk_d === 1'b1 && scan_clock === 1'b0) grp_q.push_back(scan_group);
        if (scan_complete_pulse === 1'b1 && scan_complete_pulse_d === 1'b0) strobes++;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) failures++;
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("read", rv, exp);
    endtask
    // Wait for one more strobe, then compare the groups seen on the scan port
    task automatic wait_scan(input int nch, input logic [11:0] exp);
        int n, target;
        target = strobes + 1;
        n = 0;
        while (strobes < target && n < 8000) begin
            @(posedge pclk);
            n++;
        end
        // Let the strobe end so the sequencer is idle and writes land again
        repeat (12) @(posedge pclk);
        check("strobes", strobes, target);
        check("cleared", scan_group, 4'h0);
        check("groups", grp_q.size(), nch);
        for (int i = 0; i < nch && i < grp_q.size(); i++) check("group", grp_q[i], exp[11-4*i -: 4]);
        grp_q.delete();
        $display("scan of %0d channels done", nch);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #3000000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_OFS, 32'h00006403);
        rd(DELAY_OFS, 32'h00000190);
        rd(STATUS_OFS, 32'h00000000);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped", ev, 1'b1);
        apb(1'b1, DELAY_OFS, 32'h00000000);
        rd(DELAY_OFS, 32'h00000190);
        apb(1'b1, DELAY_OFS, 32'h00007FFF);
        rd(DELAY_OFS, 32'h00007530);
        apb(1'b1, DELAY_OFS, 32'h00000190);
        apb(1'b1, CTRL_OFS, 32'h00000003);
        rd(CTRL_OFS, 32'h00000103);
        apb(1'b1, CTRL_OFS, 32'h00006503);
        rd(CTRL_OFS, 32'h00006403);
        apb(1'b1, UPPER_OFS, 32'h000003E8);
        apb(1'b1, LOWER_OFS, 32'h000001F4);
        apb(1'b1, REF_OFS, 32'h00000320);
        apb(1'b1, CTRL_OFS, 32'h00000303);
        // Absolute scan from a rising handler pulse; retrigger and writes while busy
        trigger_in <= 1'b1;
        rd(STATUS_OFS & 8'hFF, 32'h00000101);
        apb(1'b1, DELAY_OFS, 32'h00001000);
        @(posedge pclk) trigger_in <= 1'b0;
        @(posedge pclk) trigger_in <= 1'b1;
        wait_scan(3, 12'hAC9);
        rd(DELAY_OFS, 32'h00000190);
        rd(RESULT_OFS, 32'h000004B0);
        apb(1'b0, STATUS_OFS, 32'h0);
        check("status", rv & 32'h00030001, 32'h00030000);
        // Percent scan from a falling edge, slow fixture
        apb(1'b1, UPPER_OFS, 32'h0000000A);
        apb(1'b1, LOWER_OFS, 32'h00FFFFF6);
        apb(1'b1, CTRL_OFS, 32'h00000300);
        slow <= 1'b1;
        trigger_in <= 1'b0;
        wait_scan(3, 12'hAC9);
        // One channel from the start bit, value exactly on the lower limit
        apb(1'b1, UPPER_OFS, 32'h000003E8);
        apb(1'b1, LOWER_OFS, 32'h00000190);
        apb(1'b1, CTRL_OFS, 32'h00000105);
        wait_scan(1, 12'hC00);
        finish_test();
    end
endmodule
bind multichannel_scan_grader scan_grader_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in), .meas_start(meas_start),
    .meas_channel(meas_channel), .meas_valid(meas_valid), .meas_value(meas_value), .scan_group(scan_group),
    .scan_clock(scan_clock), .scan_complete_pulse(scan_complete_pulse));
